// ===== inc/ec_map.svh
// command codes, reply bytes and timing figures of the host interface
`ifndef EC_MAP_SVH
`define EC_MAP_SVH

// ----------------------------------------------------------------------
// command bytes (os set; mgmt set uses the same low bits on its base)
// ----------------------------------------------------------------------
`define OS_CMD_BASE      8'h80
`define MGMT_CMD_BASE    8'hc0
`define CMD_BASE_MASK    8'hf8
`define CMD_OP_LSB       0
`define CMD_OP_MSB       2
`define OP_BYTE_READ     3'h0
`define OP_BYTE_WRITE    3'h1
`define OP_BURST_ON      3'h2
`define OP_BURST_OFF     3'h3
`define OP_EVENT_QUERY   3'h4

// ----------------------------------------------------------------------
// reply bytes and reset values
// ----------------------------------------------------------------------
`define BURST_ACK_BYTE   8'h90
`define NO_EVENT_CODE    8'h00
`define RESET_BYTE       8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define BURST_FIRST_US   400
`define BURST_NEXT_US    50
`define BURST_TOTAL_US   1000
`define US_TO_CYC(us)    ((us) * 1000 / `CLK_PERIOD_NS)

`endif

// ===== inc/ec_pkg.sv
// types shared by the host interface command interpreter
package ec_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DATA  = 3'b010,
        ST_READ  = 3'b011,
        ST_REPLY = 3'b100
    } ec_state_e;

    typedef enum logic [2:0] {
        OP_READ      = 3'b000,
        OP_WRITE     = 3'b001,
        OP_BURST_ON  = 3'b010,
        OP_BURST_OFF = 3'b011,
        OP_QUERY     = 3'b100,
        OP_NONE      = 3'b111
    } ec_op_e;

    typedef enum logic {
        ENV_OS   = 1'b0,
        ENV_MGMT = 1'b1
    } ec_env_e;

endpackage : ec_pkg

// ===== core/ec_space_ram.sv
// byte-wide address space behind the read and write commands
`timescale 1ns/1ps
module ec_space_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock
    input  wire logic          sys_clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    // registered read data
    output logic      [DW-1:0] rdata
);
    if (AW < 1 || DW < 1)
    begin : g_check
        $error("ec_space_ram: widths must be positive");
    end

    logic [DW-1:0] mem [(1 << AW)-1:0];

    // no reset: contents are software data, read data follows next edge
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : ec_space_ram

// ===== core/ec_host_if.sv
// command interpreter of the embedded controller host interface
//
// Summary of operation
// - burst ends if no first host access within 400 us.
// - burst ends if 50 us pass between later host accesses.
// - burst ends after 1 ms total.
// - burst may drop on critical event; non-command exits interrupt the host.
// - interrupts keep coming normally while in burst.
// - in burst every access is answered within 50 us.
// - burst-on 0x82: set burst, reply 0x90, output full, interrupt.
// - burst-off 0x83: clear burst, interrupt as input empties.
// - query 0x84 returns one notification code byte.
// - code zero only means no outstanding event.
// - event sets pending flag first, then interrupts, then awaits query.
// - codes enter output buffer only as reply to a query.
// - notifications queue per environment, QD deep, dropped when full; flag only if any.
// - mgmt events use mgmt pending flag and mgmt query command.
// - separate command set per environment; replies go to issuer.
// - interrupt is a one-cycle pulse for an edge-triggered input.
// - interrupt on input empty, output full, pending flag set.
// - read: interrupt on command byte, not address, then on data.
// - write: input-empty interrupt after each of its three bytes.
// - query: no interrupt on command byte, interrupt on reply.
// - burst-on: no interrupt on command byte, interrupt on ack.
// - command port write latches byte, sets input full and command.
// - data port read clears output full.
// - 0x80 is byte read, 0x81 is byte write.
`timescale 1ns/1ps
`include "ec_map.svh"
module ec_host_if #(
    parameter int FIRST_CYC = `US_TO_CYC(`BURST_FIRST_US),
    parameter int NEXT_CYC  = `US_TO_CYC(`BURST_NEXT_US),
    parameter int TOTAL_CYC = `US_TO_CYC(`BURST_TOTAL_US),
    parameter int QD        = 4
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // host port, same clock
    input  wire logic       host_cmd_wr,
    input  wire logic       host_data_wr,
    input  wire logic [7:0] host_wdata,
    input  wire logic       host_data_rd,
    // status and output data seen by the host
    output logic      [7:0] output_data,
    output logic            output_full,
    output logic            input_full,
    output logic            cmd_flag,
    output logic            burst_mode,
    output logic            os_event_pending,
    output logic            mgmt_event_pending,
    // pulsed interrupts
    output logic            os_interrupt,
    output logic            mgmt_interrupt,
    // event sources and queue-full flags
    input  wire logic       os_event_req,
    input  wire logic [7:0] os_event_code,
    input  wire logic       mgmt_event_req,
    input  wire logic [7:0] mgmt_event_code,
    input  wire logic       critical_event,
    output logic            os_queue_full,
    output logic            mgmt_queue_full
);
    localparam int TW  = $clog2(TOTAL_CYC + 1);
    localparam int QCW = $clog2(QD + 1);

    if (QD < 1 || QD > 16 || NEXT_CYC < 1 || FIRST_CYC < 1
        || TOTAL_CYC < NEXT_CYC || TOTAL_CYC < FIRST_CYC)
    begin : g_check
        $error("ec_host_if: unusable queue depth or burst limits");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        ec_pkg::ec_state_e             state;
        ec_pkg::ec_op_e                op;
        ec_pkg::ec_env_e               env;
        logic [7:0]                    in_byte;
        logic                          input_full;
        logic                          cmd_flag;
        logic [7:0]                    reply;
        logic [7:0]                    output_data;
        logic                          output_full;
        logic                          burst_mode;
        ec_pkg::ec_env_e               burst_env;
        logic                          burst_first;
        logic [TW-1:0]                 idle_cnt;
        logic [TW-1:0]                 total_cnt;
        logic [1:0][QD-1:0][7:0]       q;
        logic [1:0][QCW-1:0]           qcnt;
        logic [1:0]                    pend;
        logic [1:0]                    qfull;
        logic [1:0]                    irq_pend;
        logic [1:0]                    intr;
        logic                          cmd_off;
    } ctl_s;

    ctl_s       s;
    ctl_s       next_s;
    logic       mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_rdata;

    // decode: low bits pick the operation, base picks the environment
    function automatic logic [3:0] decode(input logic [7:0] b);
        logic [2:0] op;
        op = b[`CMD_OP_MSB:`CMD_OP_LSB];
        decode = {1'b0, 3'b111};
        if (op <= `OP_EVENT_QUERY)
        begin
            if ((b & `CMD_BASE_MASK) == `OS_CMD_BASE)
                decode = {1'b0, op};
            else if ((b & `CMD_BASE_MASK) == `MGMT_CMD_BASE)
                decode = {1'b1, op};
        end
    endfunction : decode

    ec_space_ram #(.AW(8), .DW(8)) u_space (
        .sys_clk (sys_clk),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (s.in_byte),
        .rdata   (mem_rdata)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [1:0]     irq;
        logic [1:0]     pop;
        logic [3:0]     dec;
        logic           acc;
        logic           req;
        logic [7:0]     code;
        logic [QCW-1:0] cnt;
        next_s   = s;
        irq      = 2'b00;
        pop      = 2'b00;
        dec      = decode(s.in_byte);
        acc      = host_cmd_wr | host_data_wr | host_data_rd;
        req      = 1'b0;
        code     = `NO_EVENT_CODE;
        cnt      = '0;
        mem_we   = 1'b0;
        mem_addr = s.in_byte;
        next_s.cmd_off = 1'b0;

        case (s.state)
            ec_pkg::ST_IDLE:
            begin
                if (s.input_full)
                begin
                    next_s.input_full = 1'b0;
                    next_s.env = ec_pkg::ec_env_e'(dec[3]);
                    next_s.op  = ec_pkg::ec_op_e'(dec[2:0]);
                    if (!s.cmd_flag)
                        irq[s.env] = 1'b1;
                    else
                    begin
                        case (ec_pkg::ec_op_e'(dec[2:0]))
                            ec_pkg::OP_READ, ec_pkg::OP_WRITE:
                            begin
                                irq[dec[3]] = 1'b1;
                                next_s.state = ec_pkg::ST_ADDR;
                            end
                            ec_pkg::OP_BURST_ON:
                            begin
                                next_s.reply = `BURST_ACK_BYTE;
                                next_s.state = ec_pkg::ST_REPLY;
                            end
                            ec_pkg::OP_BURST_OFF:
                            begin
                                next_s.burst_mode = 1'b0;
                                next_s.cmd_off = s.burst_mode;
                                irq[dec[3]] = 1'b1;
                            end
                            ec_pkg::OP_QUERY:
                            begin
                                pop[dec[3]] = 1'b1;
                                next_s.reply = (s.qcnt[dec[3]] != '0)
                                    ? s.q[dec[3]][0] : `NO_EVENT_CODE;
                                next_s.state = ec_pkg::ST_REPLY;
                            end
                            default:
                                irq[dec[3]] = 1'b1;
                        endcase
                    end
                end
            end
            ec_pkg::ST_ADDR:
            begin
                // a new command byte aborts; idle then decodes it
                if (s.input_full && s.cmd_flag)
                    next_s.state = ec_pkg::ST_IDLE;
                else if (s.input_full)
                begin
                    next_s.input_full = 1'b0;
                    if (s.op == ec_pkg::OP_READ)
                        next_s.state = ec_pkg::ST_READ;
                    else
                    begin
                        irq[s.env] = 1'b1;
                        next_s.state = ec_pkg::ST_DATA;
                        next_s.reply = s.in_byte;
                    end
                end
            end
            ec_pkg::ST_DATA:
            begin
                mem_addr = s.reply;
                if (s.input_full && s.cmd_flag)
                    next_s.state = ec_pkg::ST_IDLE;
                else if (s.input_full)
                begin
                    next_s.input_full = 1'b0;
                    mem_we = 1'b1;
                    irq[s.env] = 1'b1;
                    next_s.state = ec_pkg::ST_IDLE;
                end
            end
            ec_pkg::ST_READ:
            begin
                next_s.reply = mem_rdata;
                next_s.state = ec_pkg::ST_REPLY;
            end
            ec_pkg::ST_REPLY:
            begin
                // waits for the host to drain the previous byte
                if (!s.output_full)
                begin
                    next_s.output_data = s.reply;
                    next_s.output_full = 1'b1;
                    irq[s.env] = 1'b1;
                    next_s.state = ec_pkg::ST_IDLE;
                    if (s.op == ec_pkg::OP_BURST_ON)
                    begin
                        next_s.burst_mode  = 1'b1;
                        next_s.burst_env   = s.env;
                        next_s.burst_first = 1'b1;
                        next_s.idle_cnt    = '0;
                        next_s.total_cnt   = '0;
                    end
                end
            end
            default:
                next_s.state = ec_pkg::ST_IDLE;
        endcase

        // host port after the engine: a fresh host byte wins
        if (host_cmd_wr || host_data_wr)
        begin
            next_s.in_byte    = host_wdata;
            next_s.input_full = 1'b1;
            next_s.cmd_flag   = host_cmd_wr;
        end
        // a stray read must not wipe a reply being loaded this cycle
        if (host_data_rd && s.output_full)
            next_s.output_full = 1'b0;

        // burst supervision
        if (s.burst_mode && next_s.burst_mode)
        begin
            next_s.idle_cnt  = s.idle_cnt + TW'(1);
            next_s.total_cnt = s.total_cnt + TW'(1);
            if (acc)
            begin
                next_s.idle_cnt    = '0;
                next_s.burst_first = 1'b0;
            end
            if ((s.burst_first && s.idle_cnt >= TW'(FIRST_CYC - 1))
                || (!s.burst_first && s.idle_cnt >= TW'(NEXT_CYC - 1))
                || s.total_cnt >= TW'(TOTAL_CYC - 1)
                || critical_event)
            begin
                next_s.burst_mode = 1'b0;
                irq[s.burst_env] = 1'b1;
            end
        end

        // per-environment notification queues
        for (int e = 0; e < 2; e++)
        begin
            req  = (e == 1) ? mgmt_event_req : os_event_req;
            code = (e == 1) ? mgmt_event_code : os_event_code;
            cnt  = s.qcnt[e];
            if (pop[e] && cnt != '0)
            begin
                for (int i = 0; i < QD - 1; i++)
                    next_s.q[e][i] = s.q[e][i+1];
                cnt = cnt - QCW'(1);
            end
            // zero is reserved, so it is never queued
            if (req && code != `NO_EVENT_CODE && cnt < QCW'(QD))
            begin
                next_s.q[e][cnt] = code;
                cnt = cnt + QCW'(1);
            end
            next_s.qcnt[e]  = cnt;
            next_s.pend[e]  = (cnt != '0);
            next_s.qfull[e] = (cnt == QCW'(QD));
            if (!s.pend[e] && next_s.pend[e])
                irq[e] = 1'b1;
        end

        // pulse shaper: one-cycle high, at least one low between pulses
        for (int e = 0; e < 2; e++)
        begin
            if (!s.intr[e] && s.irq_pend[e])
            begin
                next_s.intr[e]     = 1'b1;
                next_s.irq_pend[e] = irq[e];
            end
            else
            begin
                next_s.intr[e]     = 1'b0;
                next_s.irq_pend[e] = s.irq_pend[e] | irq[e];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign output_data        = s.output_data;
    assign output_full        = s.output_full;
    assign input_full         = s.input_full;
    assign cmd_flag           = s.cmd_flag;
    assign burst_mode         = s.burst_mode;
    assign os_event_pending   = s.pend[0];
    assign mgmt_event_pending = s.pend[1];
    assign os_interrupt       = s.intr[0];
    assign mgmt_interrupt     = s.intr[1];
    assign os_queue_full      = s.qfull[0];
    assign mgmt_queue_full    = s.qfull[1];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic [TW:0] quiet;
    logic        seen;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            quiet <= '0;
            seen  <= 1'b0;
        end
        else if (!s.burst_mode || host_cmd_wr || host_data_wr
                 || host_data_rd)
        begin
            quiet <= '0;
            seen  <= s.burst_mode;
        end
        else
            quiet <= quiet + (TW+1)'(1);
    end

    property p_first;
        s.burst_mode && !seen |-> quiet < (TW+1)'(FIRST_CYC);
    endproperty
    a_first: assert property (p_first) else $error("first access overrun");

    property p_next;
        s.burst_mode && seen |-> quiet < (TW+1)'(NEXT_CYC);
    endproperty
    a_next: assert property (p_next) else $error("next access overrun");

    property p_total;
        s.burst_mode |-> s.total_cnt < TW'(TOTAL_CYC);
    endproperty
    a_total: assert property (p_total) else $error("burst too long");

    property p_exit_irq;
        $fell(s.burst_mode) && !s.cmd_off |-> ##[1:3] (s.intr != 2'b00);
    endproperty
    a_exit_irq: assert property (p_exit_irq) else $error("silent exit");

    property p_burst_on;
        s.state == ec_pkg::ST_REPLY && s.op == ec_pkg::OP_BURST_ON
            && !s.output_full && !host_data_rd
        |=> s.burst_mode && s.output_full
            && s.output_data == `BURST_ACK_BYTE ##[1:3] (s.intr != 2'b00);
    endproperty
    a_burst_on: assert property (p_burst_on) else $error("bad burst ack");

    property p_empty_query;
        s.state == ec_pkg::ST_IDLE && s.input_full && s.cmd_flag
            && s.in_byte == (`OS_CMD_BASE | 8'(`OP_EVENT_QUERY))
            && s.qcnt[0] == '0
        |=> s.reply == `NO_EVENT_CODE;
    endproperty
    a_empty_query: assert property (p_empty_query) else $error("query");

    property p_no_zero;
        s.qcnt[0] != '0 |-> s.q[0][0] != `NO_EVENT_CODE;
    endproperty
    a_no_zero: assert property (p_no_zero) else $error("zero queued");

    property p_pend_irq;
        $rose(s.pend[0]) |-> ##[1:3] s.intr[0];
    endproperty
    a_pend_irq: assert property (p_pend_irq) else $error("no event irq");

    property p_cmd_latch;
        host_cmd_wr |=> s.input_full && s.cmd_flag
            && s.in_byte == $past(host_wdata);
    endproperty
    a_cmd_latch: assert property (p_cmd_latch) else $error("cmd latch");

    property p_rd_clear;
        host_data_rd && s.output_full |=> !s.output_full;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("rd clear");

    property p_pulse;
        s.intr[0] |=> !s.intr[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");

    property p_cover_burst;
        $rose(s.burst_mode);
    endproperty
    c_cover_burst: cover property (p_cover_burst);

    property p_cover_timeout;
        $fell(s.burst_mode) && !s.cmd_off;
    endproperty
    c_cover_timeout: cover property (p_cover_timeout);

    property p_cover_query;
        s.state == ec_pkg::ST_REPLY && s.reply != `NO_EVENT_CODE;
    endproperty
    c_cover_query: cover property (p_cover_query);
endmodule : ec_host_if

// ===== bench/host_model.sv
// host driver model: byte writes and reads on the two ports
`timescale 1ns/1ps
module host_model (
    // clock and device status
    input  wire logic       sys_clk,
    input  wire logic       input_full,
    input  wire logic       output_full,
    // port strobes and write byte
    output logic            host_cmd_wr,
    output logic            host_data_wr,
    output logic [7:0]      host_wdata,
    output logic            host_data_rd
);
    initial
    begin
        {host_cmd_wr, host_data_wr, host_data_rd} = 3'h0;
        host_wdata = 8'h00;
    end
    // released bus shows the inverse, so no stale byte looks valid
    task automatic put(input logic is_cmd, input logic [7:0] b);
        @(posedge sys_clk) #1;
        {host_cmd_wr, host_data_wr} = {is_cmd, !is_cmd};
        host_wdata = b;
        @(posedge sys_clk) #1;
        {host_cmd_wr, host_data_wr} = 2'h0;
        host_wdata = ~b;
        // no further byte until the device has taken this one or 40 cycles pass
        for (int n = 0; n < 40 && input_full !== 1'b0; n++)
            @(posedge sys_clk) #1;
    endtask : put
    task automatic get(input logic wait_full);
        for (int n = 0; n < 40 && wait_full && output_full !== 1'b1; n++)
            @(posedge sys_clk) #1;
        @(posedge sys_clk) #1;
        host_data_rd = 1'b1;
        @(posedge sys_clk) #1;
        host_data_rd = 1'b0;
    endtask : get
endmodule : host_model

// ===== bench/test_embedded_ctrl_burst_query_irq.sv
// self-checking bench of the host interface command interpreter
`timescale 1ns/1ps
module test_embedded_ctrl_burst_query_irq;
    logic       sys_clk, reset_n, host_cmd_wr, host_data_wr, host_data_rd;
    logic [7:0] host_wdata, output_data, os_event_code, mgmt_event_code;
    logic       output_full, input_full, cmd_flag, burst_mode;
    logic       os_event_pending, mgmt_event_pending, os_interrupt;
    logic       mgmt_interrupt, os_event_req, mgmt_event_req;
    logic       critical_event, os_queue_full, mgmt_queue_full;
    logic [7:0] expq[$];
    logic [7:0] a, d, c, base;
    int         fails = 0, comparisons = 0, os_n = 0, mg_n = 0;

    ec_host_if #(.FIRST_CYC(40), .NEXT_CYC(10), .TOTAL_CYC(100), .QD(4))
    i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .host_cmd_wr(host_cmd_wr), .host_data_wr(host_data_wr),
        .host_wdata(host_wdata), .host_data_rd(host_data_rd),
        .output_data(output_data), .output_full(output_full),
        .input_full(input_full), .cmd_flag(cmd_flag),
        .burst_mode(burst_mode), .os_event_pending(os_event_pending),
        .mgmt_event_pending(mgmt_event_pending),
        .os_interrupt(os_interrupt), .mgmt_interrupt(mgmt_interrupt),
        .os_event_req(os_event_req), .os_event_code(os_event_code),
        .mgmt_event_req(mgmt_event_req),
        .mgmt_event_code(mgmt_event_code),
        .critical_event(critical_event), .os_queue_full(os_queue_full),
        .mgmt_queue_full(mgmt_queue_full));
    host_model i_host (.sys_clk(sys_clk), .input_full(input_full),
        .output_full(output_full), .host_cmd_wr(host_cmd_wr),
        .host_data_wr(host_data_wr), .host_wdata(host_wdata),
        .host_data_rd(host_data_rd));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    // pulses are counted per window, so a missing or extra one shows
    task automatic irqs(input int o, input int m);
        wait_cyc(6);
        chk(8'(os_n), 8'(o));
        chk(8'(mg_n), 8'(m));
        os_n = 0;
        mg_n = 0;
    endtask : irqs
    task automatic evt(input logic o, input logic m, input logic [7:0] v);
        {os_event_req, mgmt_event_req} = {o, m};
        {os_event_code, mgmt_event_code} = {v, ~v};
        wait_cyc(1);
        {os_event_req, mgmt_event_req} = 2'h0;
        wait_cyc(1);
    endtask : evt
    task automatic burst_on();
        expq.push_back(8'h90);
        i_host.put(1'b1, 8'h82);
    endtask : burst_on

    always @(posedge sys_clk)
        if (host_data_rd === 1'b1 && output_full === 1'b1)
            chk(output_data, expq.pop_front());
    always @(posedge sys_clk)
    begin
        os_n += int'(os_interrupt === 1'b1);
        mg_n += int'(mgmt_interrupt === 1'b1);
    end

    initial
    begin
        #100us;
        fails++;
        complete_run();
    end

    initial
    begin
        {reset_n, os_event_req, mgmt_event_req, critical_event} = 4'h0;
        {os_event_code, mgmt_event_code} = 16'h0000;
        void'($urandom(32'h3fc3e3f4));
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk({output_full, input_full, cmd_flag, burst_mode, os_interrupt,
            os_event_pending, mgmt_event_pending, mgmt_interrupt}, 8'h00);
        chk(output_data, 8'h00);
        for (int e = 0; e < 2; e++)
        begin
            base = e ? 8'hc0 : 8'h80;
            a = 8'($urandom);
            d = 8'($urandom);
            i_host.put(1'b1, base | 8'h01);
            chk(8'(cmd_flag), 8'h01);
            i_host.put(1'b0, a);
            chk(8'(cmd_flag), 8'h00);
            i_host.put(1'b0, d);
            irqs(e ? 0 : 3, e ? 3 : 0);
            expq.push_back(d);
            i_host.put(1'b1, base);
            i_host.put(1'b0, a);
            i_host.get(1'b1);
            irqs(e ? 0 : 2, e ? 2 : 0);
            c = 8'($urandom_range(254, 1));
            evt(!e, e, c);
            chk({mgmt_event_pending, os_event_pending}, e ? 2 : 1);
            expq.push_back(e ? ~c : c);
            i_host.put(1'b1, base | 8'h04);
            i_host.get(1'b1);
            irqs(e ? 0 : 2, e ? 2 : 0);
            expq.push_back(8'h00);
            i_host.put(1'b1, base | 8'h04);
            i_host.get(1'b1);
            irqs(e ? 0 : 1, e ? 1 : 0);
            expq.push_back(8'h90);
            i_host.put(1'b1, base | 8'h02);
            wait_cyc(30);
            chk(8'(burst_mode), 8'h01);
            wait_cyc(15);
            chk(8'(burst_mode), 8'h00);
            i_host.get(1'b1);
            irqs(e ? 0 : 2, e ? 2 : 0);
        end
        burst_on();
        i_host.get(1'b1);
        chk(8'(burst_mode), 8'h01);
        i_host.put(1'b1, 8'h83);
        chk(8'(burst_mode), 8'h00);
        irqs(2, 0);
        burst_on();
        i_host.get(1'b1);
        wait_cyc(6);
        chk(8'(burst_mode), 8'h01);
        wait_cyc(8);
        chk(8'(burst_mode), 8'h00);
        irqs(2, 0);
        burst_on();
        for (int i = 0; i < 16; i++)
        begin
            if (i == 12)
                chk(8'(burst_mode), 8'h01);
            i_host.get(i == 0);
            wait_cyc(5);
        end
        chk(8'(burst_mode), 8'h00);
        irqs(2, 0);
        burst_on();
        i_host.get(1'b1);
        critical_event = 1'b1;
        wait_cyc(1);
        critical_event = 1'b0;
        wait_cyc(1);
        chk(8'(burst_mode), 8'h00);
        irqs(2, 0);
        // fill both queues past depth; the fifth code must be dropped
        for (int i = 0; i < 5; i++)
            evt(1'b1, 1'b1, 8'(i + 1));
        chk({mgmt_queue_full, os_queue_full}, 8'h03);
        for (int i = 0; i < 5; i++)
        begin
            expq.push_back(i < 4 ? 8'(i + 1) : 8'h00);
            i_host.put(1'b1, 8'h84);
            i_host.get(1'b1);
        end
        chk({mgmt_queue_full, os_queue_full, os_event_pending}, 8'h04);
        irqs(6, 1);
        complete_run();
    end
endmodule : test_embedded_ctrl_burst_query_irq
